// ---- core/i2c_line_sync.sv ----
// Three-stage synchroniser with agreement filter for one bus line.
// Assumes the input is asynchronous to pclk; output follows once
// the second and third stages agree.
`timescale 1ns/1ps
module i2c_line_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Line in and filtered level out
   input  wire logic line_i,
   output logic      level_o
);

   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic       level_q;
   logic       level_d;

   // Shift and accept a level only when stages two and three agree
   always_comb begin
      stage_d = {stage_q[1:0], line_i};
      level_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : level_q;
   end

   // Lines idle high through pull-ups
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_q <= 3'h7;
         level_q <= 1'b1;
      end else begin
         stage_q <= stage_d;
         level_q <= level_d;
      end
   end

   assign level_o = level_q;

endmodule : i2c_line_sync

// ---- core/i2c_master_controller.sv ----
// I2C bus master with APB register port, open-drain SDA/SCL and IRQ.
// Assumes external pads resolve the open-drain wires from the enables.
//
// Overview of operation
// - SCL period is 2*(6+4)*(setting+1) system clock periods.
// - Target address holds slave address in 7:1 and direction in bit 0.
// - Direction 0 sends to the slave, 1 receives from it.
// - Offset 0x004 takes four command bits, reads seven status bits.
// - Start bit makes start on idle bus, repeated start when owned.
// - Stop bit ends with stop after byte, or keeps the bus.
// - Completion or error raises interrupt; received data then valid.
// - Receive with ack bit set acknowledges each received byte.
// - Master registers decode relative to the master base address.
// - Other status bits are only meaningful once busy has cleared.
// - Error bit set on address nack, data nack or lost arbitration.
// - Bus busy set on any start, cleared on any stop.
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module i2c_master_controller
   import i2c_master_pkg::*;
(
   // APB slave port
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // Interrupt
   output logic             irq,
   // Open-drain bus lines
   input  wire logic        scl_i,
   output logic             scl_o,
   output logic             scl_oe,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe
);

   typedef enum {
      ST_IDLE, ST_START, ST_BIT_LOW, ST_BIT_HIGH, ST_ACK_LOW, ST_ACK_HIGH,
      ST_HOLD, ST_RSTART, ST_STOP_LOW, ST_STOP_HIGH
   } fsm_t;

   // ======================================================
   // Line synchronisers
   // ======================================================
   logic scl_s;
   logic sda_s;
   logic sda_s_q;
   logic scl_s_q;

   i2c_line_sync u_scl_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .line_i  (scl_i),
      .level_o (scl_s)
   );
   i2c_line_sync u_sda_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .line_i  (sda_i),
      .level_o (sda_s)
   );

   // ======================================================
   // Register file and APB decode
   // ======================================================
   logic [7:0]  addr_q,  addr_d;
   logic [7:0]  data_q,  data_d;
   logic [7:0]  tpr_q,   tpr_d;
   logic        mask_q,  mask_d;
   logic        raw_q,   raw_d;
   logic        setup_q, setup_d;
   command_t    cmd_q,   cmd_d;
   logic        go_q,    go_d;
   logic        go_keep;
   status_t     stat;
   logic        wr_en;
   logic        in_range;
   logic [7:0]  ofs;
   logic        done_pulse;
   logic [7:0]  rx_byte;
   logic        rx_load;
   logic        line_busy_q, line_busy_d;
   logic        alost_q, alost_d, dnack_q, dnack_d, anack_q, anack_d;
   fsm_t        st_q, st_d;

   assign in_range = (paddr[31:8] == MASTER_BASE[31:8]);
   assign ofs      = paddr[7:0];
   assign wr_en    = psel && penable && pwrite && in_range;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && !in_range;

   // status word, sub-flags gated by busy
   always_comb begin
      // Held bus counts as controller idle, so polling can end
      stat.busy                  = ((st_q != ST_IDLE) && (st_q != ST_HOLD))
                                   || go_q;
      stat.idle                  = !stat.busy;
      stat.line_busy_flag        = line_busy_q;
      stat.arbitration_lost_flag = stat.busy ? 1'b0 : alost_q;
      stat.data_nack_flag        = stat.busy ? 1'b0 : dnack_q;
      stat.address_nack_flag     = stat.busy ? 1'b0 : anack_q;
      stat.error                 = stat.busy ? 1'b0
                                   : (alost_q | dnack_q | anack_q);
   end

   // Read mux, unmapped reads as zero
   always_comb begin
      prdata = 32'h0000_0000;
      case (ofs)
         OFS_TARGET_ADDRESS: prdata = {24'h00_0000, addr_q};
         OFS_CMD_STATUS:     prdata = {25'h000_0000, stat};
         OFS_TRANSFER_BYTE:  prdata = {24'h00_0000, data_q};
         OFS_SCL_PERIOD:     prdata = {24'h00_0000, tpr_q};
         OFS_IRQ_MASK:       prdata = {31'h0000_0000, mask_q};
         OFS_IRQ_RAW:        prdata = {31'h0000_0000, raw_q};
         OFS_IRQ_MASKED:     prdata = {31'h0000_0000, raw_q & mask_q};
         OFS_MASTER_SETUP:   prdata = {26'h000_0000, setup_q, 5'h00};
         default:            prdata = 32'h0000_0000;
      endcase
   end

   // Register next values
   always_comb begin
      addr_d  = addr_q;
      data_d  = rx_load ? rx_byte : data_q;
      tpr_d   = tpr_q;
      mask_d  = mask_q;
      setup_d = setup_q;
      cmd_d   = cmd_q;
      go_d    = go_keep ? go_q : 1'b0;
      raw_d   = raw_q;
      if (wr_en) begin
         case (ofs)
            OFS_TARGET_ADDRESS: addr_d = pwdata[7:0];
            OFS_TRANSFER_BYTE:  data_d = pwdata[7:0];
            OFS_SCL_PERIOD:     tpr_d  = pwdata[7:0];
            OFS_IRQ_MASK:       mask_d = pwdata[0];
            OFS_MASTER_SETUP:   setup_d = pwdata[SETUP_MASTER_BIT + 1];
            OFS_CMD_STATUS: begin
               cmd_d = pwdata[3:0];
               go_d  = pwdata[CMD_RUN_BIT] | pwdata[CMD_STOP_BIT];
            end
            OFS_IRQ_CLEAR: if (pwdata[0]) raw_d = 1'b0;
            default: ;
         endcase
      end
      // completion sets flag, set wins over clear
      if (done_pulse) raw_d = 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q  <= 8'h00;
         data_q  <= 8'h00;
         tpr_q   <= SCL_PERIOD_RESET;
         mask_q  <= 1'b0;
         raw_q   <= 1'b0;
         setup_q <= 1'b0;
         cmd_q   <= 4'h0;
         go_q    <= 1'b0;
      end else begin
         addr_q  <= addr_d;
         data_q  <= data_d;
         tpr_q   <= tpr_d;
         mask_q  <= mask_d;
         raw_q   <= raw_d;
         setup_q <= setup_d;
         cmd_q   <= cmd_d;
         go_q    <= go_d;
      end
   end

   assign irq = raw_q & mask_q;

   // ======================================================
   // SCL phase timing, ten phase units per period
   // ======================================================
   // each phase unit is 2*(tpr+1) clocks
   logic [8:0] pre_q, pre_d;
   logic [3:0] ph_q,  ph_d;
   logic       tick;
   logic       phase_end;
   logic [3:0] ph_len;

   assign tick = (pre_q == {tpr_q, 1'b1});
   always_comb begin
      pre_d = tick ? 9'h000 : pre_q + 9'h001;
      ph_d  = ph_q;
      if (st_d != st_q) begin
         pre_d = 9'h000;
         ph_d  = 4'h0;
      end else if (tick) begin
         ph_d = ph_q + 4'h1;
      end
   end
   // low weight 6, high weight 4
   assign ph_len = (st_q == ST_BIT_HIGH || st_q == ST_ACK_HIGH
                    || st_q == ST_STOP_HIGH || st_q == ST_START)
                   ? 4'(HIGH_PHASE_WEIGHT) : 4'(LOW_PHASE_WEIGHT);
   assign phase_end = tick && (ph_q == ph_len - 4'h1);

   // ======================================================
   // Bus protocol state machine
   // ======================================================
   logic [7:0] sh_q, sh_d;
   logic [2:0] bit_q, bit_d;
   logic       is_addr_q, is_addr_d;
   logic       rx_q, rx_d;
   logic       sda_lo_q, sda_lo_d;
   logic       scl_lo_q, scl_lo_d;
   logic       own_q, own_d;
   logic       done_q, done_d;
   logic       start_bit, stop_bit, ack_bit;

   assign start_bit = cmd_q.start;
   assign stop_bit  = cmd_q.stop;
   assign ack_bit   = cmd_q.ack;
   assign rx_byte   = sh_q;
   assign rx_load   = done_q && rx_q;
   assign done_pulse = done_q;

   always_comb begin
      st_d = st_q; sh_d = sh_q; bit_d = bit_q; is_addr_d = is_addr_q;
      rx_d = rx_q; sda_lo_d = sda_lo_q; scl_lo_d = scl_lo_q;
      own_d = own_q; done_d = 1'b0;
      go_keep = 1'b0;
      alost_d = alost_q; dnack_d = dnack_q; anack_d = anack_q;
      case (st_q)
         ST_IDLE, ST_HOLD: begin
            if (go_q && setup_q && !(st_q == ST_IDLE && addr_q[DIR_BIT]
                && ack_bit && stop_bit && start_bit && cmd_q.run)) begin
               alost_d = 1'b0; dnack_d = 1'b0; anack_d = 1'b0;
               if (start_bit && cmd_q.run) begin
                  // first byte is address with direction
                  sh_d = addr_q; is_addr_d = 1'b1;
                  rx_d = 1'b0; bit_d = 3'h7;
                  st_d = own_q ? ST_RSTART : ST_START;
                  // defer to a start seen on the line
                  if (!own_q && line_busy_q) begin
                     st_d = st_q;
                     go_keep = 1'b1;
                  end
               end else if (st_q == ST_HOLD && cmd_q.run) begin
                  rx_d = addr_q[DIR_BIT]; is_addr_d = 1'b0;
                  sh_d = data_q; bit_d = 3'h7; st_d = ST_BIT_LOW;
               end else if (st_q == ST_HOLD && stop_bit) begin
                  st_d = ST_STOP_LOW;
               end
            end
         end
         ST_RSTART: begin
            sda_lo_d = 1'b0; scl_lo_d = 1'b0;
            if (phase_end) begin scl_lo_d = 1'b0; st_d = ST_START; end
         end
         ST_START: begin
            scl_lo_d = 1'b0; sda_lo_d = 1'b1;
            own_d = 1'b1;
            if (phase_end) begin scl_lo_d = 1'b1; st_d = ST_BIT_LOW; end
         end
         ST_BIT_LOW: begin
            scl_lo_d = 1'b1;
            sda_lo_d = rx_q ? 1'b0 : !sh_q[7];
            if (phase_end) begin scl_lo_d = 1'b0; st_d = ST_BIT_HIGH; end
         end
         ST_BIT_HIGH: if (scl_s && phase_end) begin
            // Arbitration: drove high but line low
            if (!rx_q && sh_q[7] && !sda_s) begin
               alost_d = 1'b1; own_d = 1'b0; sda_lo_d = 1'b0;
               done_d = 1'b1; st_d = ST_IDLE;
            end else begin
               sh_d = {sh_q[6:0], sda_s};
               scl_lo_d = 1'b1;
               bit_d = bit_q - 3'h1;
               st_d = (bit_q == 3'h0) ? ST_ACK_LOW : ST_BIT_LOW;
            end
         end
         ST_ACK_LOW: begin
            scl_lo_d = 1'b1;
            // ack on receive when ack bit set, release on send or without ack bit
            sda_lo_d = rx_q && ack_bit;
            if (phase_end) begin scl_lo_d = 1'b0; st_d = ST_ACK_HIGH; end
         end
         ST_ACK_HIGH: if (scl_s && phase_end) begin
            scl_lo_d = 1'b1;
            if (!rx_q && sda_s) begin
               if (is_addr_q) anack_d = 1'b1; else dnack_d = 1'b1;
               st_d = ST_STOP_LOW;
            end else if (is_addr_q) begin
               is_addr_d = 1'b0; rx_d = addr_q[DIR_BIT];
               sh_d = data_q; bit_d = 3'h7; st_d = ST_BIT_LOW;
            end else begin
               st_d = stop_bit ? ST_STOP_LOW : ST_HOLD;
               if (!stop_bit) done_d = 1'b1;
            end
         end
         ST_STOP_LOW: begin
            scl_lo_d = 1'b1; sda_lo_d = 1'b1;
            if (phase_end) begin scl_lo_d = 1'b0; st_d = ST_STOP_HIGH; end
         end
         ST_STOP_HIGH: if (phase_end) begin
            sda_lo_d = 1'b0; own_d = 1'b0;
            done_d = 1'b1; st_d = ST_IDLE;
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // bus busy from start/stop seen on the lines
   always_comb begin
      line_busy_d = line_busy_q;
      if (scl_s && scl_s_q && sda_s_q && !sda_s) line_busy_d = 1'b1;
      if (scl_s && scl_s_q && !sda_s_q && sda_s) line_busy_d = 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q <= ST_IDLE; sh_q <= 8'h00; bit_q <= 3'h0;
         is_addr_q <= 1'b0; rx_q <= 1'b0; sda_lo_q <= 1'b0;
         scl_lo_q <= 1'b0; own_q <= 1'b0; done_q <= 1'b0;
         alost_q <= 1'b0; dnack_q <= 1'b0; anack_q <= 1'b0;
         pre_q <= 9'h000; ph_q <= 4'h0; line_busy_q <= 1'b0;
         sda_s_q <= 1'b1; scl_s_q <= 1'b1;
      end else begin
         st_q <= st_d; sh_q <= sh_d; bit_q <= bit_d;
         is_addr_q <= is_addr_d; rx_q <= rx_d; sda_lo_q <= sda_lo_d;
         scl_lo_q <= scl_lo_d; own_q <= own_d; done_q <= done_d;
         alost_q <= alost_d; dnack_q <= dnack_d; anack_q <= anack_d;
         pre_q <= pre_d; ph_q <= ph_d; line_busy_q <= line_busy_d;
         sda_s_q <= sda_s; scl_s_q <= scl_s;
      end
   end

   // Open-drain drive: output low while enabled
   assign sda_o  = 1'b0;
   assign scl_o  = 1'b0;
   assign sda_oe = sda_lo_q;
   assign scl_oe = scl_lo_q;

   // ======================================================
   // Assertions
   // ======================================================
   AST_IRQ_LEVEL:
      assert property (@(posedge pclk) disable iff (!presetn)
         done_q |=> raw_q) else $error("completion did not set flag");
   AST_MASKED:
      assert property (@(posedge pclk) disable iff (!presetn)
         (wr_en && ofs == OFS_IRQ_CLEAR && pwdata[0] && !done_pulse)
         |=> !irq) else $error("clear left irq high");
   AST_SDA_STABLE:
      assert property (@(posedge pclk) disable iff (!presetn)
         (st_q == ST_BIT_HIGH && $stable(st_q)) |-> $stable(sda_oe))
      else $error("sda changed while scl high");
   AST_ACK_RELEASE:
      assert property (@(posedge pclk) disable iff (!presetn)
         (st_q == ST_ACK_HIGH && !rx_q) |-> !sda_oe)
      else $error("sda held in ack slot");
   AST_ERR_CAUSE:
      assert property (@(posedge pclk) disable iff (!presetn)
         (st_q == ST_ACK_HIGH && is_addr_q && !rx_q && scl_s
          && phase_end && sda_s) |=> anack_q)
      else $error("address nack not flagged");
   AST_ILLEGAL:
      assert property (@(posedge pclk) disable iff (!presetn)
         (st_q == ST_IDLE && go_q && cmd_q == 4'hF && addr_q[0])
         |=> st_q == ST_IDLE) else $error("illegal command ran");
   AST_RX_ACK:
      assert property (@(posedge pclk) disable iff (!presetn)
         (st_q == ST_ACK_HIGH && rx_q && ack_bit) |-> sda_oe)
      else $error("no ack driven");
   AST_STOP_BUSY:
      assert property (@(posedge pclk) disable iff (!presetn)
         (scl_s && scl_s_q && !sda_s_q && sda_s) |=> !line_busy_q)
      else $error("stop did not clear busy");

endmodule : i2c_master_controller

// ---- core/i2c_master_pkg.sv ----
// Constants, register map and types for the I2C bus master.
// Assumes an APB slave port with 32-bit data and word-aligned registers.
package i2c_master_pkg;

   // ======================================================
   // Register map (byte offsets from the master base)
   // ======================================================
   localparam logic [31:0] MASTER_BASE         = 32'h4002_0000;
   localparam logic [31:0] SLAVE_BASE          = 32'h4002_0800;
   localparam logic [7:0]  OFS_TARGET_ADDRESS  = 8'h00;
   localparam logic [7:0]  OFS_CMD_STATUS      = 8'h04;
   localparam logic [7:0]  OFS_TRANSFER_BYTE   = 8'h08;
   localparam logic [7:0]  OFS_SCL_PERIOD      = 8'h0C;
   localparam logic [7:0]  OFS_IRQ_MASK        = 8'h10;
   localparam logic [7:0]  OFS_IRQ_RAW         = 8'h14;
   localparam logic [7:0]  OFS_IRQ_MASKED      = 8'h18;
   localparam logic [7:0]  OFS_IRQ_CLEAR       = 8'h1C;
   localparam logic [7:0]  OFS_MASTER_SETUP    = 8'h20;

   // ======================================================
   // Reset values and field positions
   // ======================================================
   localparam logic [7:0]  SCL_PERIOD_RESET    = 8'h01;
   localparam int          CMD_RUN_BIT         = 0;
   localparam int          CMD_START_BIT       = 1;
   localparam int          CMD_STOP_BIT        = 2;
   localparam int          CMD_ACK_BIT         = 3;
   localparam int          SETUP_MASTER_BIT    = 4;
   localparam int          DIR_BIT             = 0;

   // ======================================================
   // SCL timing weights
   // ======================================================
   localparam int          LOW_PHASE_WEIGHT    = 6;
   localparam int          HIGH_PHASE_WEIGHT   = 4;

   // Controller status as read from the command/status word
   typedef struct packed {
      logic line_busy_flag;
      logic idle;
      logic arbitration_lost_flag;
      logic data_nack_flag;
      logic address_nack_flag;
      logic error;
      logic busy;
   } status_t;

   // Command bits written to the command/status word
   typedef struct packed {
      logic ack;
      logic stop;
      logic start;
      logic run;
   } command_t;

endpackage : i2c_master_pkg

// ---- testbench/i2c_slave_model.sv ----
// Behavioural I2C slave for the master bench.
// Assumes the bench resolves both pulled-up lines from all enables.
`timescale 1ns/1ps
module i2c_slave_model #(
   parameter logic [6:0] OWN_ADDR = 7'h3B
) (
   // Resolved bus lines
   input  wire logic scl,
   input  wire logic sda,
   // Data line pull-down
   output logic      sda_oe
);
   logic [7:0] rx_q[$];
   logic [7:0] tx_q[$];
   logic       ack_q[$];

   // ==========================================
   // Byte helpers
   // ==========================================
   // Shift in one byte on rising clock edges
   task automatic get_byte(output logic [7:0] b);
      repeat (8) begin
         @(posedge scl);
         b = {b[6:0], sda};
      end
   endtask : get_byte

   // One addressed frame; data changes only while clock is low
   task automatic frame();
      logic [7:0] b;
      get_byte(b);
      rx_q.push_back(b);
      if (b[7:1] != OWN_ADDR) return;
      @(negedge scl);
      sda_oe = 1'b1;
      if (b[0] == 1'b0) begin
         forever begin
            @(negedge scl);
            sda_oe = 1'b0;
            get_byte(b);
            rx_q.push_back(b);
            @(negedge scl);
            sda_oe = 1'b1;
         end
      end
      forever begin
         b = tx_q.pop_front();
         for (int i = 7; i >= 0; i--) begin
            @(negedge scl);
            sda_oe = ~b[i];
         end
         @(negedge scl);
         sda_oe = 1'b0;
         @(posedge scl);
         ack_q.push_back(sda);
         if (sda) return;
      end
   endtask : frame

   // ==========================================
   // Frame tracking: start, repeated start, stop
   // ==========================================
   initial begin
      sda_oe = 1'b0;
      forever begin
         if (!(scl === 1'b1 && sda === 1'b0))
            @(negedge sda iff scl === 1'b1);
         fork
            frame();
            @(sda iff scl === 1'b1);
         join_any
         disable fork;
         sda_oe = 1'b0;
      end
   end
endmodule : i2c_slave_model

// ---- testbench/tb.sv ----
// Self-checking bench for the I2C bus master controller.
// Assumes the slave model and pull-ups on both bus lines.
`timescale 1ns/1ps
module tb;
   import i2c_master_pkg::*;
   typedef struct {
      logic [31:0] exp;
      logic [31:0] msk;
      string       name;
   } note_t;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd_v;
   logic        pready, pslverr, irq, scl_o, scl_oe, sda_o, sda_oe;
   logic        s_oe, err_v;
   int          failures = 0, total_checks = 0, cyc = 0;
   note_t       notes[$];
   note_t       n;
   event        got;
   logic [7:0]  ofs_l[8] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18,
                             8'h20, 8'h24};
   wire         scl = ~scl_oe;
   wire         sda = ~(sda_oe | s_oe);

   i2c_master_controller dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .scl_i(scl),
      .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
      .sda_oe(sda_oe));
   i2c_slave_model slv_u (.scl(scl), .sda(sda), .sda_oe(s_oe));

   // ==========================================
   // Clock, timeout and comparisons
   // ==========================================
   always #4 pclk = ~pclk;

   // Cut a hang short
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 60000) begin
         failures++;
         tally_and_finish();
      end
   end

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Oldest read note against the data read
   initial forever begin
      @(got);
      n = notes.pop_front();
      check(n.name, rd_v & n.msk, n.exp);
   end

   task automatic tally_and_finish();
      if (failures == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : tally_and_finish

   // ==========================================
   // APB master tasks
   // ==========================================
   task automatic apb(logic w, logic [31:0] a, logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd_v = prdata;
      err_v = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(logic [7:0] o, logic [31:0] d);
      apb(1'b1, MASTER_BASE + 32'(o), d);
   endtask : wr

   task automatic rd(logic [7:0] o, logic [31:0] e, logic [31:0] m,
                     string nm);
      apb(1'b0, MASTER_BASE + 32'(o), 32'h0);
      notes.push_back('{e, m, nm});
      -> got;
   endtask : rd

   // Poll status until the given bit reads zero
   task automatic poll(int b);
      do apb(1'b0, MASTER_BASE + 32'(OFS_CMD_STATUS), 32'h0);
      while (rd_v[b] !== 1'b0);
   endtask : poll

   // Clock low and high phase lengths in pclk cycles
   task automatic measure(output int lo, output int hi);
      @(negedge scl);
      @(negedge scl);
      lo = 0;
      hi = 0;
      @(negedge pclk);
      while (scl === 1'b0) begin
         lo++;
         @(negedge pclk);
      end
      while (scl === 1'b1) begin
         hi++;
         @(negedge pclk);
      end
   endtask : measure

   // ==========================================
   // Main sequence
   // ==========================================
   initial begin
      logic [7:0] d1, r1, r2;
      int         lo, hi;
      void'($urandom(32'hBB62));
      d1 = 8'($urandom);
      r1 = 8'($urandom);
      r2 = 8'($urandom);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (ofs_l[i])
         rd(ofs_l[i], (ofs_l[i] == 8'h0C) ? 32'h1 : 32'h0, '1, "reset");
      apb(1'b1, SLAVE_BASE, 32'hFF);
      check("page error", 32'(err_v), 32'h1);
      rd(OFS_TARGET_ADDRESS, 32'h0, '1, "no write");
      wr(OFS_MASTER_SETUP, 32'h20);
      wr(OFS_TARGET_ADDRESS, 32'h76);
      wr(OFS_TRANSFER_BYTE, 32'(d1));
      rd(OFS_TARGET_ADDRESS, 32'h76, '1, "address");
      wr(OFS_IRQ_MASK, 32'h1);
      // Single send with clock timing
      fork
         wr(OFS_CMD_STATUS, 32'h7);
         measure(lo, hi);
      join
      poll(0);
      poll(6);
      check("scl low", 32'(lo),
            32'(LOW_PHASE_WEIGHT * 2 * (SCL_PERIOD_RESET + 1)));
      check("scl high", 32'(hi),
            32'(HIGH_PHASE_WEIGHT * 2 * (SCL_PERIOD_RESET + 1)));
      check("drive lows", 32'({scl_o, sda_o}), 32'h0);
      check("addr byte", 32'(slv_u.rx_q.pop_front()), 32'h76);
      check("data byte", 32'(slv_u.rx_q.pop_front()), 32'(d1));
      rd(OFS_CMD_STATUS, 32'h0, 32'h5F, "send status");
      check("irq on", 32'(irq), 32'h1);
      rd(OFS_IRQ_MASKED, 32'h1, '1, "masked");
      wr(OFS_IRQ_CLEAR, 32'h1);
      check("irq off", 32'(irq), 32'h0);
      rd(OFS_IRQ_RAW, 32'h0, '1, "raw clear");
      // Burst send, repeated start, receive with and without ack
      wr(OFS_CMD_STATUS, 32'h3);
      poll(0);
      rd(OFS_CMD_STATUS, 32'h40, 32'h41, "bus held");
      wr(OFS_TARGET_ADDRESS, 32'h77);
      slv_u.tx_q.push_back(r1);
      slv_u.tx_q.push_back(r2);
      wr(OFS_CMD_STATUS, 32'hB);
      poll(0);
      rd(OFS_TRANSFER_BYTE, 32'(r1), 32'hFF, "rx byte 1");
      wr(OFS_CMD_STATUS, 32'h5);
      poll(0);
      poll(6);
      rd(OFS_TRANSFER_BYTE, 32'(r2), 32'hFF, "rx byte 2");
      check("burst addr", 32'(slv_u.rx_q.pop_front()), 32'h76);
      check("burst data", 32'(slv_u.rx_q.pop_front()), 32'(d1));
      check("restart addr", 32'(slv_u.rx_q.pop_front()), 32'h77);
      check("ack", 32'(slv_u.ack_q.pop_front()), 32'h0);
      check("nack", 32'(slv_u.ack_q.pop_front()), 32'h1);
      // Address not acknowledged, interrupt masked off
      wr(OFS_IRQ_CLEAR, 32'h1);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_TARGET_ADDRESS, 32'hA0);
      wr(OFS_CMD_STATUS, 32'h7);
      poll(0);
      poll(6);
      rd(OFS_CMD_STATUS, 32'h6, 32'h1F, "addr nack");
      check("nack addr", 32'(slv_u.rx_q.pop_front()), 32'hA0);
      rd(OFS_IRQ_RAW, 32'h1, '1, "raw set");
      rd(OFS_IRQ_MASKED, 32'h0, '1, "masked off");
      check("irq masked", 32'(irq), 32'h0);
      // Illegal receive command from idle
      wr(OFS_TARGET_ADDRESS, 32'h77);
      wr(OFS_CMD_STATUS, 32'hF);
      repeat (300) @(posedge pclk);
      rd(OFS_CMD_STATUS, 32'h0, 32'h41, "illegal");
      check("no frame", 32'(slv_u.rx_q.size()), 32'h0);
      tally_and_finish();
   end
endmodule : tb
